// >>> include/rt_seq_pkg.sv
// Sequencer constants: timing, map, bits, resets.
// Assumes a 125 MHz clock and 16-bit RAM words.
package rt_seq_pkg;
    localparam int CLK_PERIOD_NS = 8;
    localparam int SOM_DELAY_NS = 1250;
    localparam int EOM_DELAY_NS = 6000;
    localparam int SOM_CYC = (SOM_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int EOM_CYC = (EOM_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 10;

    localparam logic [4:0] OFS_CFG = 5'h00;
    localparam logic [4:0] OFS_SPLOC = 5'h04;
    localparam logic [4:0] OFS_ILLBASE = 5'h08;
    localparam logic [4:0] OFS_BUSYBASE = 5'h0c;
    localparam logic [4:0] OFS_SACWBASE = 5'h10;
    localparam logic [4:0] OFS_DBABASE = 5'h14;
    localparam logic [4:0] OFS_STATUS = 5'h18;
    localparam logic [4:0] OFS_LASTBSW = 5'h1c;

    localparam int CFG_ILL_EN = 0;
    localparam int CFG_BUF_MGMT = 1;
    localparam int CFG_BUSY_EN = 2;
    localparam int CFG_MODE_STORE = 3;
    localparam int CFG_BCAST_REJECT = 7;
    localparam logic [7:0] CFG_RST = 8'h00;
    localparam logic [15:0] BASE_RST = 16'h0000;

    localparam logic [15:0] BSW_SOM_VAL = 16'h4000;
    localparam int BSW_EOM = 15;
    localparam int BSW_BCAST = 9;
    localparam int BSW_ILLEGAL = 8;
    localparam int BSW_NORESP = 3;
    localparam int BSW_FMT_ERR = 2;

    localparam int TST_PARITY = 4;
    localparam int TST_NORESP = 2;

    localparam int SACW_CIRC = 0;
    localparam int SACW_IRQ = 4;
    localparam int SACW_DBL = 15;
    localparam logic [15:0] DBL_TOGGLE = 16'h0020;

    localparam int ST_MSG_ERR = 9;
    localparam int ST_BCAST = 10;
    localparam int ST_BUSY = 11;
    localparam int ST_ACTIVE = 12;

    localparam logic [4:0] BCAST_ADDR = 5'h1f;
    localparam logic [15:0] SP_STEP = 16'h0004;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// >>> rtl/rt_message_memory_sequencer.sv
// Message start/end RAM sequences, AXI4-Lite setup.
// Assumes same-clock pulses and a RAM that acks.
//
// Overview of operation
// - Start sequence begins 1.25 us after command.
// - End sequence begins 6 us after last word.
// - Read illegalization entry first when enabled.
// - Read stack pointer, address descriptor block.
// - Read busy table entry when enabled.
// - Buffer option reads subaddress control word.
// - Read data block address unless excepted.
// - Write command, data address, time tag.
// - Write block status 4000 hex.
// - Write stack pointer plus four back.
// - End sequence rereads control word if buffered.
// - Receive double buffering rereads data address.
// - Mode storage writes mode data word three.
// - Mode storage skips word three without data.
// - Buffered pointer update written to table.
// - End with time tag, then block status.
// - Invalid command ignored completely.
// - Address parity: own ignored, broadcast optional, irq.
// - Bad data: no response, errors, events.
// - Silent transmitter: no response, errors, events.
// - Clean message: status, broadcast flag, events.
`timescale 1ns/100ps
module rt_message_memory_sequencer #(
    parameter int AW = 16
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [4:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [4:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [4:0] rtAddr,
    input wire logic cmdValid,
    input wire logic [15:0] cmdWord,
    input wire logic cmdInvalid,
    input wire logic addrParityErr,
    input wire logic lastWordDone,
    input wire logic dataInvalid,
    input wire logic rtRtNoResp,
    input wire logic [15:0] msgWordCount,
    input wire logic [15:0] modeData,
    input wire logic [15:0] timeTag,
    input wire logic modeIrqSel,
    output logic memReq,
    output logic memWe,
    output logic [AW-1:0] memAddr,
    output logic [15:0] memWdata,
    input wire logic memAck,
    input wire logic [15:0] memRdata,
    output logic sendStatus,
    output logic eomEvt,
    output logic fmtErrEvt,
    output logic saEvt,
    output logic termAddrParityIrq
);
    typedef enum logic [4:0] {
        S_IDLE, S_SOMWAIT, S_ILL, S_SPRD, S_BUSY, S_SACW, S_DBARD, S_CMDWR,
        S_DBAWR, S_TTWR, S_BSWWR, S_SPWR, S_MSG, S_EOMWAIT, S_ESACW, S_EDBA,
        S_EMODE, S_EPTR, S_ETT, S_EBSW
    } seq_e;

    seq_e st_q, st_d;
    logic [rt_seq_pkg::CNT_W-1:0] cnt_q, cnt_d;
    logic req_q, req_d, we_q, we_d;
    logic [AW-1:0] addr_q, addr_d;
    logic [15:0] wdat_q, wdat_d;
    logic [15:0] cmd_q, cmd_d, sp_q, sp_d, sacw_q, sacw_d, dba_q, dba_d;
    logic [15:0] ill_q, ill_d, bsw_q, bsw_d, tt_q, tt_d;
    logic bcast_q, bcast_d, busy_q, busy_d;
    logic done_q, done_d, dErr_q, dErr_d, nResp_q, nResp_d;
    logic msgErr_q, msgErr_d, bcRcvd_q, bcRcvd_d;
    logic [8:0] test_q, test_d;
    logic send_q, send_d, eom_q, eom_d, fmt_q, fmt_d, sa_q, sa_d, api_q, api_d;
    logic [7:0] cfg_q, cfg_d;
    logic [15:0] spLoc_q, spLoc_d, illB_q, illB_d, busyB_q, busyB_d;
    logic [15:0] sacwB_q, sacwB_d, dbaB_q, dbaB_d;
    logic awRdy_q, awRdy_d, wRdy_q, wRdy_d, bv_q, bv_d, rv_q, rv_d, arRdy_q;
    logic [4:0] awa_q, awa_d;
    logic [31:0] wd_q, wd_d, rd_q, rd_d;
    logic [1:0] br_q, br_d, rr_q, rr_d;

    logic act, isMem, isMode, modeNoData, modeWithData, rxDbl, bufUsed, ptrUpd;
    logic ownHit, bcHit, errMsg;
    logic [15:0] a, wd;
    seq_e nxt;

    assign isMode = (cmd_q[9:5] == 5'h00) || (cmd_q[9:5] == 5'h1f);
    assign modeWithData = isMode && cmd_q[4];
    assign modeNoData = isMode && !cmd_q[4];
    assign bufUsed = sacw_q[rt_seq_pkg::SACW_CIRC] || sacw_q[rt_seq_pkg::SACW_DBL];
    assign rxDbl = sacw_q[rt_seq_pkg::SACW_DBL] && !cmd_q[10];
    assign ptrUpd = cfg_q[rt_seq_pkg::CFG_BUF_MGMT] && bufUsed && !isMode;
    assign ownHit = (cmdWord[15:11] == rtAddr);
    assign bcHit = (cmdWord[15:11] == rt_seq_pkg::BCAST_ADDR);
    assign errMsg = dErr_q || nResp_q;

    // Sequencer next state
    always_comb
    begin
        st_d = st_q;
        cnt_d = cnt_q;
        req_d = req_q;
        we_d = we_q;
        addr_d = addr_q;
        wdat_d = wdat_q;
        cmd_d = cmd_q;
        sp_d = sp_q;
        sacw_d = sacw_q;
        dba_d = dba_q;
        ill_d = ill_q;
        bsw_d = bsw_q;
        tt_d = tt_q;
        bcast_d = bcast_q;
        busy_d = busy_q;
        done_d = done_q;
        dErr_d = dErr_q;
        nResp_d = nResp_q;
        msgErr_d = msgErr_q;
        bcRcvd_d = bcRcvd_q;
        test_d = test_q;
        send_d = 1'b0;
        eom_d = 1'b0;
        fmt_d = 1'b0;
        sa_d = 1'b0;
        api_d = 1'b0;
        act = 1'b0;
        isMem = 1'b1;
        a = 16'h0000;
        wd = 16'h0000;
        nxt = st_q;
        case (st_q)
            S_ILL:
            begin
                act = cfg_q[rt_seq_pkg::CFG_ILL_EN];
                a = illB_q + {10'h000, cmd_q[15:11] == rt_seq_pkg::BCAST_ADDR, cmd_q[10:6]};
                nxt = S_SPRD;
            end
            S_SPRD:
            begin
                act = 1'b1;
                a = spLoc_q;
                nxt = S_BUSY;
            end
            S_BUSY:
            begin
                act = cfg_q[rt_seq_pkg::CFG_BUSY_EN];
                a = busyB_q + {10'h000, bcast_q, cmd_q[10:6]};
                nxt = S_SACW;
            end
            S_SACW:
            begin
                act = cfg_q[rt_seq_pkg::CFG_BUF_MGMT];
                a = sacwB_q + {11'h000, cmd_q[9:5]};
                nxt = S_DBARD;
            end
            S_DBARD:
            begin
                act = !modeNoData && !cfg_q[rt_seq_pkg::CFG_MODE_STORE];
                a = dbaB_q + {10'h000, cmd_q[10:5]};
                nxt = S_CMDWR;
            end
            S_CMDWR:
            begin
                act = 1'b1;
                a = sp_q + 16'h0003;
                wd = cmd_q;
                nxt = S_DBAWR;
            end
            S_DBAWR:
            begin
                act = !modeNoData && !cfg_q[rt_seq_pkg::CFG_MODE_STORE];
                a = sp_q + 16'h0002;
                wd = dba_q;
                nxt = S_TTWR;
            end
            S_TTWR:
            begin
                act = 1'b1;
                a = sp_q + 16'h0001;
                wd = tt_q;
                nxt = S_BSWWR;
            end
            S_BSWWR:
            begin
                act = 1'b1;
                a = sp_q;
                wd = rt_seq_pkg::BSW_SOM_VAL;
                nxt = S_SPWR;
            end
            S_SPWR:
            begin
                act = 1'b1;
                a = spLoc_q;
                wd = sp_q + rt_seq_pkg::SP_STEP;
                nxt = S_MSG;
            end
            S_ESACW:
            begin
                act = cfg_q[rt_seq_pkg::CFG_BUF_MGMT] && bufUsed;
                a = sacwB_q + {11'h000, cmd_q[9:5]};
                nxt = S_EDBA;
            end
            S_EDBA:
            begin
                act = cfg_q[rt_seq_pkg::CFG_BUF_MGMT] && rxDbl && !isMode;
                a = dbaB_q + {10'h000, cmd_q[10:5]};
                nxt = S_EMODE;
            end
            S_EMODE:
            begin
                act = cfg_q[rt_seq_pkg::CFG_MODE_STORE] && modeWithData;
                a = sp_q + 16'h0002;
                wd = modeData;
                nxt = S_EPTR;
            end
            S_EPTR:
            begin
                act = ptrUpd;
                a = dbaB_q + {10'h000, cmd_q[10:5]};
                wd = sacw_q[rt_seq_pkg::SACW_CIRC] ? dba_q + msgWordCount
                    : dba_q ^ rt_seq_pkg::DBL_TOGGLE;
                nxt = S_ETT;
            end
            S_ETT:
            begin
                act = 1'b1;
                a = sp_q + 16'h0001;
                wd = tt_q;
                nxt = S_EBSW;
            end
            S_EBSW:
            begin
                act = 1'b1;
                a = sp_q;
                wd = bsw_q;
                nxt = S_IDLE;
            end
            default: isMem = 1'b0;
        endcase

        if ((st_q != S_IDLE) && (st_q < S_EOMWAIT) && lastWordDone && !done_q)
        begin
            done_d = 1'b1;
            dErr_d = dataInvalid;
            nResp_d = rtRtNoResp;
            tt_d = timeTag;
        end

        if (isMem)
        begin
            if (!act) st_d = nxt;
            else if (!req_q)
            begin
                req_d = 1'b1;
                addr_d = a[AW-1:0];
                we_d = (st_q >= S_CMDWR && st_q != S_ESACW && st_q != S_EDBA);
                wdat_d = wd;
            end
            else if (memAck)
            begin
                req_d = 1'b0;
                we_d = 1'b0;
                st_d = nxt;
                case (st_q)
                    S_ILL: ill_d = memRdata;
                    S_SPRD: sp_d = memRdata;
                    S_BUSY: busy_d = memRdata[cmd_q[3:0]];
                    S_SACW, S_ESACW: sacw_d = memRdata;
                    S_DBARD, S_EDBA: dba_d = memRdata;
                    S_EBSW:
                    begin
                        eom_d = 1'b1;
                        fmt_d = errMsg;
                        sa_d = sacw_q[rt_seq_pkg::SACW_IRQ] || (isMode && modeIrqSel);
                        test_d = 9'h000;
                        test_d[rt_seq_pkg::TST_PARITY] = dErr_q;
                        test_d[rt_seq_pkg::TST_NORESP] = nResp_q;
                    end
                    default: ;
                endcase
            end
        end
        else
        begin
            case (st_q)
                S_IDLE:
                begin
                    if (cmdValid && !cmdInvalid)
                    begin
                        api_d = addrParityErr;
                        if ((bcHit && !(addrParityErr && cfg_q[rt_seq_pkg::CFG_BCAST_REJECT]))
                            || (ownHit && !addrParityErr))
                        begin
                            st_d = S_SOMWAIT;
                            cnt_d = '0;
                            cmd_d = cmdWord;
                            bcast_d = bcHit;
                            tt_d = timeTag;
                            sacw_d = 16'h0000;
                            ill_d = 16'h0000;
                            busy_d = 1'b0;
                            done_d = 1'b0;
                        end
                    end
                end
                S_SOMWAIT:
                begin
                    cnt_d = cnt_q + 1'b1;
                    if (cnt_q == rt_seq_pkg::CNT_W'(rt_seq_pkg::SOM_CYC - 1))
                    begin
                        st_d = S_ILL;
                        tt_d = timeTag;
                    end
                end
                S_MSG:
                begin
                    if (done_q)
                    begin
                        st_d = S_EOMWAIT;
                        cnt_d = '0;
                        msgErr_d = errMsg;
                        bcRcvd_d = bcast_q;
                        send_d = !errMsg && !bcast_q;
                        bsw_d = 16'h0000;
                        bsw_d[rt_seq_pkg::BSW_EOM] = 1'b1;
                        bsw_d[rt_seq_pkg::BSW_BCAST] = bcast_q;
                        bsw_d[rt_seq_pkg::BSW_FMT_ERR] = errMsg;
                        bsw_d[rt_seq_pkg::BSW_NORESP] = nResp_q;
                        bsw_d[rt_seq_pkg::BSW_ILLEGAL] = ill_q[cmd_q[3:0]];
                    end
                end
                S_EOMWAIT:
                begin
                    cnt_d = cnt_q + 1'b1;
                    if (cnt_q == rt_seq_pkg::CNT_W'(rt_seq_pkg::EOM_CYC - 1))
                    begin
                        st_d = S_ESACW;
                        tt_d = timeTag;
                    end
                end
                default: st_d = S_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st_q <= S_IDLE;
            cnt_q <= '0;
            req_q <= 1'b0;
            we_q <= 1'b0;
            addr_q <= '0;
            wdat_q <= 16'h0000;
            cmd_q <= 16'h0000;
            sp_q <= 16'h0000;
            sacw_q <= 16'h0000;
            dba_q <= 16'h0000;
            ill_q <= 16'h0000;
            bsw_q <= 16'h0000;
            tt_q <= 16'h0000;
            bcast_q <= 1'b0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
            dErr_q <= 1'b0;
            nResp_q <= 1'b0;
            msgErr_q <= 1'b0;
            bcRcvd_q <= 1'b0;
            test_q <= 9'h000;
            send_q <= 1'b0;
            eom_q <= 1'b0;
            fmt_q <= 1'b0;
            sa_q <= 1'b0;
            api_q <= 1'b0;
        end
        else
        begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            req_q <= req_d;
            we_q <= we_d;
            addr_q <= addr_d;
            wdat_q <= wdat_d;
            cmd_q <= cmd_d;
            sp_q <= sp_d;
            sacw_q <= sacw_d;
            dba_q <= dba_d;
            ill_q <= ill_d;
            bsw_q <= bsw_d;
            tt_q <= tt_d;
            bcast_q <= bcast_d;
            busy_q <= busy_d;
            done_q <= done_d;
            dErr_q <= dErr_d;
            nResp_q <= nResp_d;
            msgErr_q <= msgErr_d;
            bcRcvd_q <= bcRcvd_d;
            test_q <= test_d;
            send_q <= send_d;
            eom_q <= eom_d;
            fmt_q <= fmt_d;
            sa_q <= sa_d;
            api_q <= api_d;
        end
    end

    // AXI4-Lite slave next state
    always_comb
    begin
        awRdy_d = awRdy_q;
        wRdy_d = wRdy_q;
        awa_d = awa_q;
        wd_d = wd_q;
        bv_d = bv_q;
        br_d = br_q;
        rv_d = rv_q;
        rd_d = rd_q;
        rr_d = rr_q;
        cfg_d = cfg_q;
        spLoc_d = spLoc_q;
        illB_d = illB_q;
        busyB_d = busyB_q;
        sacwB_d = sacwB_q;
        dbaB_d = dbaB_q;
        if (s_axi_awvalid && awRdy_q)
        begin
            awRdy_d = 1'b0;
            awa_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && wRdy_q)
        begin
            wRdy_d = 1'b0;
            wd_d = s_axi_wdata;
        end
        if (bv_q && s_axi_bready) bv_d = 1'b0;
        if (!awRdy_q && !wRdy_q && !bv_q)
        begin
            awRdy_d = 1'b1;
            wRdy_d = 1'b1;
            bv_d = 1'b1;
            br_d = rt_seq_pkg::RESP_OKAY;
            case ({awa_q[4:2], 2'b00})
                rt_seq_pkg::OFS_CFG: cfg_d = wd_q[7:0];
                rt_seq_pkg::OFS_SPLOC: spLoc_d = wd_q[15:0];
                rt_seq_pkg::OFS_ILLBASE: illB_d = wd_q[15:0];
                rt_seq_pkg::OFS_BUSYBASE: busyB_d = wd_q[15:0];
                rt_seq_pkg::OFS_SACWBASE: sacwB_d = wd_q[15:0];
                rt_seq_pkg::OFS_DBABASE: dbaB_d = wd_q[15:0];
                rt_seq_pkg::OFS_STATUS, rt_seq_pkg::OFS_LASTBSW: ;
                default: br_d = rt_seq_pkg::RESP_SLVERR;
            endcase
        end
        if (rv_q && s_axi_rready) rv_d = 1'b0;
        if (s_axi_arvalid && !rv_q)
        begin
            rv_d = 1'b1;
            rr_d = rt_seq_pkg::RESP_OKAY;
            rd_d = 32'h0000_0000;
            case ({s_axi_araddr[4:2], 2'b00})
                rt_seq_pkg::OFS_CFG: rd_d[7:0] = cfg_q;
                rt_seq_pkg::OFS_SPLOC: rd_d[15:0] = spLoc_q;
                rt_seq_pkg::OFS_ILLBASE: rd_d[15:0] = illB_q;
                rt_seq_pkg::OFS_BUSYBASE: rd_d[15:0] = busyB_q;
                rt_seq_pkg::OFS_SACWBASE: rd_d[15:0] = sacwB_q;
                rt_seq_pkg::OFS_DBABASE: rd_d[15:0] = dbaB_q;
                rt_seq_pkg::OFS_STATUS:
                begin
                    rd_d[8:0] = test_q;
                    rd_d[rt_seq_pkg::ST_MSG_ERR] = msgErr_q;
                    rd_d[rt_seq_pkg::ST_BCAST] = bcRcvd_q;
                    rd_d[rt_seq_pkg::ST_BUSY] = busy_q;
                    rd_d[rt_seq_pkg::ST_ACTIVE] = (st_q != S_IDLE);
                end
                rt_seq_pkg::OFS_LASTBSW: rd_d[15:0] = bsw_q;
                default: rr_d = rt_seq_pkg::RESP_SLVERR;
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            awRdy_q <= 1'b1;
            wRdy_q <= 1'b1;
            arRdy_q <= 1'b1;
            awa_q <= 5'h00;
            wd_q <= 32'h0000_0000;
            bv_q <= 1'b0;
            br_q <= 2'h0;
            rv_q <= 1'b0;
            rd_q <= 32'h0000_0000;
            rr_q <= 2'h0;
            cfg_q <= rt_seq_pkg::CFG_RST;
            spLoc_q <= rt_seq_pkg::BASE_RST;
            illB_q <= rt_seq_pkg::BASE_RST;
            busyB_q <= rt_seq_pkg::BASE_RST;
            sacwB_q <= rt_seq_pkg::BASE_RST;
            dbaB_q <= rt_seq_pkg::BASE_RST;
        end
        else
        begin
            awRdy_q <= awRdy_d;
            wRdy_q <= wRdy_d;
            arRdy_q <= !rv_d;
            awa_q <= awa_d;
            wd_q <= wd_d;
            bv_q <= bv_d;
            br_q <= br_d;
            rv_q <= rv_d;
            rd_q <= rd_d;
            rr_q <= rr_d;
            cfg_q <= cfg_d;
            spLoc_q <= spLoc_d;
            illB_q <= illB_d;
            busyB_q <= busyB_d;
            sacwB_q <= sacwB_d;
            dbaB_q <= dbaB_d;
        end
    end

    assign s_axi_awready = awRdy_q;
    assign s_axi_wready = wRdy_q;
    assign s_axi_bvalid = bv_q;
    assign s_axi_bresp = br_q;
    assign s_axi_arready = arRdy_q;
    assign s_axi_rvalid = rv_q;
    assign s_axi_rdata = rd_q;
    assign s_axi_rresp = rr_q;
    assign memReq = req_q;
    assign memWe = we_q;
    assign memAddr = addr_q;
    assign memWdata = wdat_q;
    assign sendStatus = send_q;
    assign eomEvt = eom_q;
    assign fmtErrEvt = fmt_q;
    assign saEvt = sa_q;
    assign termAddrParityIrq = api_q;
endmodule // rt_message_memory_sequencer

// >>> sim/ram_model.sv
// Shared RAM partner: 64K words, acks after lat cycles.
// Assumes requests held until memAck.
`timescale 1ns/100ps
module ram_model (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic memReq,
    input wire logic memWe,
    input wire logic [15:0] memAddr,
    input wire logic [15:0] memWdata,
    input wire logic [3:0] lat,
    output logic memAck,
    output logic [15:0] memRdata
);
    logic [15:0] mem [0:65535];
    logic [3:0] waitQ;
    // Read bus toggles when idle
    always @(posedge clk or negedge arst_n)
        if (!arst_n)
        begin
            waitQ <= 4'h0;
            memAck <= 1'b0;
            memRdata <= 16'h0000;
        end
        else
        begin
            memAck <= 1'b0;
            memRdata <= ~memRdata;
            if (memReq && !memAck && waitQ == lat)
            begin
                memAck <= 1'b1;
                waitQ <= 4'h0;
                memRdata <= mem[memAddr];
                if (memWe) mem[memAddr] <= memWdata;
            end
            else if (memReq && !memAck) waitQ <= waitQ + 4'h1;
        end
endmodule // ram_model

// >>> sim/rt_message_memory_sequencer_assertions.sv
// Checker on sequencer ports.
// Bound to the sequencer module.
`timescale 1ns/100ps
module rt_seq_checker (
    input wire logic clk, arst_n, cmdValid, cmdInvalid, addrParityErr,
    input wire logic memReq, memAck, eomEvt, fmtErrEvt, saEvt, termAddrParityIrq,
    input wire logic [15:0] memAddr
);
    logic [10:0] quietQ;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    // Idle after a long quiet gap
    always_ff @(posedge clk or negedge arst_n)
        if (!arst_n) quietQ <= 11'h000;
        else if (memReq) quietQ <= 11'h000;
        else if (!quietQ[10]) quietQ <= quietQ + 11'h001;
    start_delay_a: assert property (cmdValid && !cmdInvalid && !addrParityErr && quietQ[10]
        |=> !memReq [*8] ##[140:160] memReq) else $error("start late");
    ignore_cmd_a: assert property (cmdValid && cmdInvalid && quietQ[10]
        |=> (!memReq && !termAddrParityIrq) [*8]) else $error("invalid acted on");
    parity_irq_a: assert property (cmdValid && !cmdInvalid && addrParityErr && quietQ[10]
        |-> ##[1:2] termAddrParityIrq) else $error("no parity irq");
    req_hold_a: assert property (memReq && !memAck |=> memReq && $stable(memAddr))
        else $error("request dropped");
    req_drop_a: assert property (memReq && memAck |=> !memReq)
        else $error("request kept");
    fmt_eom_a: assert property (fmtErrEvt |-> eomEvt)
        else $error("format without end");
    sa_eom_a: assert property (saEvt |-> eomEvt)
        else $error("lone sa event");
    eom_ack_a: assert property (eomEvt |-> memAck || $past(memAck))
        else $error("end not at ack");
endmodule // rt_seq_checker

// >>> sim/tb_rt_message_memory_sequencer.sv
// Bench: AXI4-Lite setup, messages, RAM log checks.
// Assumes rtAddr 5.
`timescale 1ns/100ps
module tb_rt_message_memory_sequencer;
    logic clk = 1'b0, arst_n = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [4:0] s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic cmdValid = 1'b0, cmdInvalid = 1'b0, addrParityErr = 1'b0;
    logic lastWordDone = 1'b0, dataInvalid = 1'b0;
    logic [15:0] cmdWord = 16'h0, modeData = 16'h0abc, timeTag = 16'h0123;
    logic [15:0] memAddr, memWdata, memRdata;
    logic memReq, memWe, memAck, sendStatus, eomEvt, fmtErrEvt, saEvt, termAddrParityIrq;
    logic [3:0] lat = 4'h0;
    logic [32:0] log[$], ex[$];
    int fail_count = 0, tests_run = 0, nStat = 0, nEom = 0, nFmt = 0, nIrq = 0, early;
    rt_message_memory_sequencer i_dut (.*, .s_axi_wstrb(4'hf), .rtAddr(5'h05),
        .rtRtNoResp(1'b0), .msgWordCount(16'h0), .modeIrqSel(1'b0));
    ram_model i_ram (.*);
    always #4 clk = ~clk;
    always @(negedge clk)
    begin
        if (memReq && memAck) log.push_back({memWe, memAddr, memWe ? memWdata : 16'h0});
        nStat += sendStatus; nEom += eomEvt; nFmt += fmtErrEvt; nIrq += termAddrParityIrq;
    end
    function automatic logic [32:0] w(logic [15:0] a, logic [15:0] v); return {1'b1, a, v};
    endfunction
    function automatic logic [32:0] r(logic [15:0] a); return {1'b0, a, 16'h0}; endfunction
    task chk(input logic [32:0] got, input logic [32:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            fail_count++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task cmpLog; chk(33'(log.size()), 33'(ex.size())); foreach (ex[i]) chk(log[i], ex[i]);
    endtask
    task axw(input logic [4:0] a, input logic [31:0] v);
        logic ta, tw, tb;
        @(posedge clk); s_axi_awaddr <= a; s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
        do begin
            @(negedge clk); ta = s_axi_awready; tw = s_axi_wready; tb = s_axi_bvalid;
            @(posedge clk); if (ta) s_axi_awvalid <= 1'b0; if (tw) s_axi_wvalid <= 1'b0;
        end while (!tb);
        s_axi_bready <= 1'b0;
    endtask
    task axr(input logic [4:0] a);
        logic ta, tv;
        @(posedge clk); s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
        do begin
            @(negedge clk); ta = s_axi_arready; tv = s_axi_rvalid; d = s_axi_rdata; rs = s_axi_rresp;
            @(posedge clk); if (ta) s_axi_arvalid <= 1'b0;
        end while (!tv);
        s_axi_rready <= 1'b0;
    endtask
    task msg(input logic [15:0] c, input logic bad);
        log.delete(); nStat = 0; nEom = 0; nFmt = 0;
        repeat (1100) @(posedge clk); cmdWord <= c; cmdValid <= 1'b1;
        @(posedge clk); cmdValid <= 1'b0;
        repeat (400) @(posedge clk); dataInvalid <= bad; lastWordDone <= 1'b1;
        @(posedge clk); lastWordDone <= 1'b0; dataInvalid <= 1'b0;
        repeat (740) @(posedge clk); early = log.size();
        repeat (300) @(posedge clk);
    endtask
    task t_basic;
        axw(rt_seq_pkg::OFS_SPLOC, 32'h100); axw(rt_seq_pkg::OFS_DBABASE, 32'h400);
        i_ram.mem[16'h0100] = 16'h0200; i_ram.mem[16'h0403] = 16'h0777;
        msg(16'h2862, 1'b0);
        ex = '{r(16'h0100), r(16'h0403), w(16'h0203, 16'h2862), w(16'h0202, 16'h0777),
            w(16'h0201, 16'h0123), w(16'h0200, 16'h4000), w(16'h0100, 16'h0204),
            w(16'h0201, 16'h0123), w(16'h0200, 16'h8000)};
        cmpLog;
        chk(33'(early), 33'h7);
        chk(33'(nStat * 2 + nEom), 33'h3);
        $display("basic done");
    endtask
    task t_mode;
        lat = 4'h3; axw(rt_seq_pkg::OFS_CFG, 32'h8);
        msg(16'h2c12, 1'b1);
        ex = '{r(16'h0100), w(16'h0207, 16'h2c12), w(16'h0205, 16'h0123),
            w(16'h0204, 16'h4000), w(16'h0100, 16'h0208), w(16'h0206, 16'h0abc),
            w(16'h0205, 16'h0123), w(16'h0204, 16'h8004)};
        cmpLog;
        chk(33'(nStat * 2 + nFmt), 33'h1);
        axr(rt_seq_pkg::OFS_STATUS); chk({1'b0, d & 32'h210}, 33'h210);
        axr(rt_seq_pkg::OFS_CFG); chk({rs, d[30:0]}, {rt_seq_pkg::RESP_OKAY, 31'h8});
        $display("mode done");
    endtask
    task ign(input logic inv, input logic par, input int irqExp);
        log.delete(); repeat (1100) @(posedge clk); nIrq = 0;
        cmdWord <= 16'h2862; cmdInvalid <= inv; addrParityErr <= par; cmdValid <= 1'b1;
        @(posedge clk); cmdValid <= 1'b0; cmdInvalid <= 1'b0; addrParityErr <= 1'b0;
        repeat (1000) @(posedge clk);
        chk(33'(log.size()), 33'h0);
        chk(33'(nIrq), 33'(irqExp));
        $display("ignore done");
    endtask
    task wrap_up;
        $display("comparisons %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial
    begin
        repeat (20) @(posedge clk); arst_n <= 1'b1;
        t_basic; t_mode; ign(1'b1, 1'b0, 0); ign(1'b0, 1'b1, 1);
        wrap_up;
    end
    initial
    begin
        #200000; fail_count++; $display("BAD %0t watchdog expired", $time); wrap_up;
    end
endmodule // tb_rt_message_memory_sequencer
bind rt_message_memory_sequencer rt_seq_checker i_chk (.*);
